// ==== src/ucer_map.vh ====
// Purpose: Constants for the control endpoint responder
// Assumes: Included by bare name from the design files
// Notes:   Offsets are APB byte addresses
`ifndef UCER_MAP_VH
`define UCER_MAP_VH

`define UCER_OFF_MODE     8'h00
`define UCER_OFF_COUNT    8'h04
`define UCER_OFF_BUF      8'h20
`define UCER_BUF_MASK     8'he0

// Mode register fields
`define UCER_MODE_LSB     0
`define UCER_ACK_BIT      4
`define UCER_OUT_BIT      5
`define UCER_IN_BIT       6
`define UCER_SETUP_BIT    7

// Count register fields
`define UCER_CNT_LSB      0
`define UCER_DVAL_BIT     6
`define UCER_DATA_TOGGLE_FIELD_BIT     7

// Endpoint mode codes
`define UCER_M_DISABLE    4'h0
`define UCER_M_NAK_IO     4'h1
`define UCER_M_STS_OUT    4'h2
`define UCER_M_STALL_IO   4'h3
`define UCER_M_STS_IN     4'h6
`define UCER_M_ACKOUT_SI  4'hb
`define UCER_M_ACKIN_SO   4'hf

// Token codes
`define UCER_TOK_SETUP    2'h0
`define UCER_TOK_IN       2'h1
`define UCER_TOK_OUT      2'h2

// Handshake codes
`define UCER_HS_ACK       2'h0
`define UCER_HS_NAK       2'h1
`define UCER_HS_STALL     2'h2

// Packet lengths
`define UCER_MAX_LEN      4'ha
`define UCER_STS_LEN      4'h2

`define UCER_RST_MODE     4'h0
`endif

// ==== src/ucer_buf.v ====
// Purpose: Endpoint data buffer, one write and two read ports
// Assumes: Writes happen on mclk while ce is high
// Notes:   Contents are not reset, as on the real buffer
`timescale 1ns/100ps
module ucer_buf #(
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire          mclk,
  input  wire          ce,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [7:0]    wdata,
  input  wire [AW-1:0] raddr_a,
  output wire [7:0]    rdata_a,
  input  wire [AW-1:0] raddr_b,
  output wire [7:0]    rdata_b
);

  reg [7:0] mem [0:DEPTH-1];

  always @(posedge mclk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];

endmodule // ucer_buf

// ==== src/ucer_responder.v ====
// Purpose: Control endpoint token responder with APB registers
// Assumes: Decoded token and packet events arrive synchronous to mclk
// Notes:   ce low freezes every flop, the APB slave included
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/100ps
`include "ucer_map.vh"

// Overview of operation
// (RQ1) Mode 0000 ignores everything, changes nothing
// (RQ2) SETUP over 10 bytes ignored, no handshake
// (RQ3) Invalid short SETUP ignored, no handshake
// (RQ4) Valid SETUP: ACK, flags, mode 0001, irq
// (RQ5) Mode 0011 IN gets STALL only
// (RQ6) Mode 0011 valid OUT STALL; bad OUT ignored
// (RQ7) Mode 0001 IN gets NAK only
// (RQ8) Mode 0001 valid OUT NAK; bad OUT ignored
// (RQ9) Ignored long SETUP may corrupt buffer
// (RQ10) Mode 1111 IN sends data; ack advances
// (RQ11) Mode 1111 OUT length not 2: STALL
// (RQ12) Mode 1111 2-byte OUT toggle 0: STALL
// (RQ13) Mode 1111 good status: ACK, mode 0010
// (RQ14) Mode 0010 IN: STALL, mode 0011, irq
// (RQ15) Mode 0010 bad status OUT: STALL, 0011
// (RQ16) Mode 0010 good status: ACK, mode kept
// (RQ17) Mode 1011 IN sends zero-length packet
// (RQ18) Data IN length equals count field
// (RQ19) Firmware avoids reserved mode codes
// (RQ20) Token fully handled before next accepted
module ucer_responder #(
  parameter AW = 8
) (
  input  wire          mclk,
  input  wire          rst,
  input  wire          ce,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [AW-1:0] paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  input  wire          tok_valid,
  input  wire [1:0]    tok_pid,
  output reg           tok_ready,
  input  wire          rx_byte_valid,
  input  wire [7:0]    rx_byte,
  input  wire          rx_end,
  input  wire          rx_good,
  input  wire          rx_toggle,
  output reg           hs_valid,
  output reg  [1:0]    hs_code,
  output reg           tx_start,
  output reg  [3:0]    tx_len,
  output reg           tx_valid,
  output reg  [7:0]    tx_data,
  input  wire          tx_ready,
  input  wire          host_ack,
  input  wire          host_noack,
  output reg           ep_irq
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_RX   = 2'h1;
  localparam [1:0] ST_TX   = 2'h2;
  localparam [1:0] ST_WAIT = 2'h3;

  // Codes the engine acts on; reserved ones are treated as disabled
  function ctl_mode;
    input [3:0] m;
    begin
      case (m)
        `UCER_M_NAK_IO, `UCER_M_STS_OUT, `UCER_M_STALL_IO,
        `UCER_M_STS_IN, `UCER_M_ACKOUT_SI, `UCER_M_ACKIN_SO: ctl_mode = 1'b1;
        default: ctl_mode = 1'b0;
      endcase
    end
  endfunction

  reg [1:0] state_reg;
  reg [3:0] mode_reg;
  reg       setup_f_reg;
  reg       in_f_reg;
  reg       out_f_reg;
  reg       ack_f_reg;
  reg       tog_reg;
  reg       dval_reg;
  reg [3:0] cnt_reg;
  reg [1:0] pid_reg;
  reg       store_reg;
  reg       skip_reg;
  reg [3:0] rx_cnt_reg;
  reg [3:0] tx_idx_reg;

  wire [7:0] buf_rd_a;
  wire [7:0] buf_rd_b;

  // APB decode
  wire apb_acc  = psel && penable;
  wire apb_fire = apb_acc && pready;
  wire is_mode  = (paddr == `UCER_OFF_MODE);
  wire is_cnt   = (paddr == `UCER_OFF_COUNT);
  wire is_buf   = ((paddr & `UCER_BUF_MASK) == `UCER_OFF_BUF) && (paddr[1:0] == 2'h0);
  wire mapped   = is_mode || is_cnt || is_buf;
  wire apb_wr   = apb_fire && pwrite;

  // Data written while receiving; a junk packet may overwrite it
  wire rx_we   = (state_reg == ST_RX) && store_reg && rx_byte_valid &&
                 (rx_cnt_reg < 4'h8); // see (RQ9)
  wire buf_we  = rx_we || (apb_wr && is_buf);
  wire [2:0] buf_wa = rx_we ? rx_cnt_reg[2:0] : paddr[4:2];
  wire [7:0] buf_wd = rx_we ? rx_byte : pwdata[7:0];

  ucer_buf #(
    .DEPTH (8),
    .AW    (3)
  ) u_buf (
    .mclk    (mclk),
    .ce      (ce),
    .we      (buf_we),
    .waddr   (buf_wa),
    .wdata   (buf_wd),
    .raddr_a (paddr[4:2]),
    .rdata_a (buf_rd_a),
    .raddr_b (tx_idx_reg[2:0]),
    .rdata_b (buf_rd_b)
  );

  // Decision at the end of a SETUP or OUT data packet
  reg       d_hs;
  reg [1:0] d_code;
  reg       d_ld;
  reg [3:0] d_mode;
  reg       d_set;
  reg       d_out;
  reg       d_upd;
  reg       d_sts;
  wire      too_long = (rx_cnt_reg > `UCER_MAX_LEN);
  wire      pkt_ok   = rx_good && !too_long && !skip_reg; // see (RQ2) (RQ3)
  wire      good_sts = (rx_cnt_reg == `UCER_STS_LEN) && rx_toggle;

  always @* begin
    d_hs   = 1'b0;
    d_code = `UCER_HS_ACK;
    d_ld   = 1'b0;
    d_mode = mode_reg;
    d_set  = 1'b0;
    d_out  = 1'b0;
    d_upd  = 1'b0;
    d_sts  = 1'b0;
    if (pkt_ok && pid_reg == `UCER_TOK_SETUP) begin
      d_hs   = 1'b1; // see (RQ4)
      d_ld   = 1'b1;
      d_mode = `UCER_M_NAK_IO;
      d_set  = 1'b1;
      d_upd  = 1'b1;
    end else if (pkt_ok) begin
      case (mode_reg)
        `UCER_M_STALL_IO: begin
          d_hs   = 1'b1; // see (RQ6)
          d_code = `UCER_HS_STALL;
        end
        `UCER_M_NAK_IO: begin
          d_hs   = 1'b1; // see (RQ8)
          d_code = `UCER_HS_NAK;
        end
        `UCER_M_ACKIN_SO, `UCER_M_STS_OUT: begin
          d_hs = 1'b1;
          d_ld = 1'b1;
          if (good_sts) begin
            d_out = 1'b1; // see (RQ13) (RQ16)
            d_sts = 1'b1;
            d_mode = `UCER_M_STS_OUT;
          end else begin
            d_code = `UCER_HS_STALL; // see (RQ11) (RQ12) (RQ15)
            d_mode = `UCER_M_STALL_IO;
          end
        end
        `UCER_M_ACKOUT_SI: begin
          d_hs   = 1'b1;
          d_ld   = 1'b1;
          d_mode = `UCER_M_NAK_IO;
          d_out  = 1'b1;
          d_upd  = 1'b1;
        end
        `UCER_M_STS_IN: begin
          d_hs   = 1'b1;
          d_ld   = 1'b1;
          d_code = `UCER_HS_STALL;
          d_mode = `UCER_M_STALL_IO;
        end
        default: begin
          d_hs = 1'b0;
        end
      endcase
    end
  end

  wire rx_done = (state_reg == ST_RX) && rx_end;
  wire ev_rx   = rx_done && d_ld;
  wire ev_tx   = (state_reg == ST_WAIT) && host_ack;
  wire tok_in  = tok_valid && tok_ready && (tok_pid == `UCER_TOK_IN);
  wire in_stall_sts = tok_in && (mode_reg == `UCER_M_STS_OUT);

  // Register read mux
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    if (is_mode) begin
      rd_mux[`UCER_MODE_LSB+3:`UCER_MODE_LSB] = mode_reg;
      rd_mux[`UCER_ACK_BIT]   = ack_f_reg;
      rd_mux[`UCER_OUT_BIT]   = out_f_reg;
      rd_mux[`UCER_IN_BIT]    = in_f_reg;
      rd_mux[`UCER_SETUP_BIT] = setup_f_reg;
    end else if (is_cnt) begin
      rd_mux[`UCER_CNT_LSB+3:`UCER_CNT_LSB] = cnt_reg;
      rd_mux[`UCER_DVAL_BIT] = dval_reg;
      rd_mux[`UCER_DATA_TOGGLE_FIELD_BIT] = tog_reg;
    end else if (is_buf) begin
      rd_mux[7:0] = buf_rd_a;
    end
  end

  // APB slave, one wait state per access
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= apb_acc && !pready;
      pslverr <= apb_acc && !pready && !mapped;
      if (apb_acc && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // Endpoint registers; hardware events win over a same-cycle write
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_reg    <= `UCER_RST_MODE;
      setup_f_reg <= 1'b0;
      in_f_reg    <= 1'b0;
      out_f_reg   <= 1'b0;
      ack_f_reg   <= 1'b0;
      tog_reg     <= 1'b0;
      dval_reg    <= 1'b0;
      cnt_reg     <= 4'h0;
    end else if (ce) begin
      if (apb_wr && is_mode) begin
        mode_reg    <= pwdata[`UCER_MODE_LSB+3:`UCER_MODE_LSB];
        ack_f_reg   <= pwdata[`UCER_ACK_BIT];
        out_f_reg   <= pwdata[`UCER_OUT_BIT];
        in_f_reg    <= pwdata[`UCER_IN_BIT];
        setup_f_reg <= pwdata[`UCER_SETUP_BIT];
      end
      if (apb_wr && is_cnt) begin
        cnt_reg  <= pwdata[`UCER_CNT_LSB+3:`UCER_CNT_LSB];
        dval_reg <= pwdata[`UCER_DVAL_BIT];
        tog_reg  <= pwdata[`UCER_DATA_TOGGLE_FIELD_BIT];
      end
      if (ev_rx) begin
        mode_reg <= d_mode;
        if (d_hs && d_code == `UCER_HS_ACK) begin
          ack_f_reg <= 1'b1;
        end
        if (d_set) begin
          setup_f_reg <= 1'b1;
        end
        if (d_out) begin
          out_f_reg <= 1'b1;
        end
        if (d_upd) begin
          cnt_reg  <= rx_cnt_reg;
          tog_reg  <= rx_toggle;
          dval_reg <= 1'b1;
        end
        if (d_sts) begin
          cnt_reg  <= `UCER_STS_LEN;
          tog_reg  <= 1'b1;
          dval_reg <= 1'b1;
        end
      end
      if (in_stall_sts) begin
        mode_reg <= `UCER_M_STALL_IO; // see (RQ14)
      end
      if (ev_tx) begin
        in_f_reg  <= 1'b1; // see (RQ10) (RQ17)
        ack_f_reg <= 1'b1;
        mode_reg  <= (mode_reg == `UCER_M_ACKIN_SO) ? `UCER_M_NAK_IO : `UCER_M_STALL_IO;
      end
    end
  end

  // Token sequencer
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg  <= ST_IDLE;
      tok_ready  <= 1'b0;
      pid_reg    <= `UCER_TOK_SETUP;
      store_reg  <= 1'b0;
      skip_reg   <= 1'b0;
      rx_cnt_reg <= 4'h0;
      tx_idx_reg <= 4'h0;
      hs_valid   <= 1'b0;
      hs_code    <= `UCER_HS_ACK;
      tx_start   <= 1'b0;
      tx_len     <= 4'h0;
      tx_valid   <= 1'b0;
      tx_data    <= 8'h00;
      ep_irq     <= 1'b0;
    end else if (ce) begin
      hs_valid <= 1'b0;
      tx_start <= 1'b0;
      ep_irq   <= 1'b0;
      // Ready only in idle, so no token overlaps an update
      tok_ready <= (state_reg == ST_IDLE) && !(tok_valid && tok_ready); // see (RQ20)
      case (state_reg)
        ST_IDLE: begin
          if (tok_valid && tok_ready) begin
            pid_reg    <= tok_pid;
            rx_cnt_reg <= 4'h0;
            tx_idx_reg <= 4'h0;
            // Disabled or reserved codes skip the packet untouched
            skip_reg   <= !ctl_mode(mode_reg); // see (RQ1) (RQ19)
            store_reg  <= ctl_mode(mode_reg) &&
                          (tok_pid == `UCER_TOK_SETUP ||
                           mode_reg == `UCER_M_ACKOUT_SI);
            if (tok_pid != `UCER_TOK_IN) begin
              state_reg <= ST_RX;
            end else begin
              case (mode_reg)
                `UCER_M_STALL_IO, `UCER_M_STS_OUT: begin
                  hs_valid <= 1'b1; // see (RQ5) (RQ14)
                  hs_code  <= `UCER_HS_STALL;
                  ep_irq   <= (mode_reg == `UCER_M_STS_OUT);
                  state_reg <= ST_IDLE;
                end
                `UCER_M_NAK_IO: begin
                  hs_valid <= 1'b1; // see (RQ7)
                  hs_code  <= `UCER_HS_NAK;
                  state_reg <= ST_IDLE;
                end
                `UCER_M_ACKIN_SO: begin
                  tx_start  <= 1'b1;
                  tx_len    <= cnt_reg; // see (RQ18)
                  state_reg <= ST_TX;
                end
                `UCER_M_ACKOUT_SI, `UCER_M_STS_IN: begin
                  tx_start  <= 1'b1;
                  tx_len    <= 4'h0; // see (RQ17)
                  state_reg <= ST_TX;
                end
                default: begin
                  state_reg <= ST_IDLE; // see (RQ1)
                end
              endcase
            end
          end
        end
        ST_RX: begin
          // Count saturates; anything past ten is already too long
          if (rx_byte_valid && rx_cnt_reg != 4'hf) begin
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
          end
          if (rx_end) begin
            hs_valid  <= d_hs;
            hs_code   <= d_code;
            ep_irq    <= d_ld;
            state_reg <= ST_IDLE;
          end
        end
        ST_TX: begin
          if (!tx_valid || tx_ready) begin
            if (tx_idx_reg == tx_len) begin
              tx_valid  <= 1'b0;
              state_reg <= ST_WAIT;
            end else begin
              tx_valid   <= 1'b1;
              tx_data    <= buf_rd_b;
              tx_idx_reg <= tx_idx_reg + 4'h1;
            end
          end
        end
        ST_WAIT: begin
          // No acknowledge from the host leaves every register as is
          if (host_ack) begin
            ep_irq    <= 1'b1;
            state_reg <= ST_IDLE;
          end else if (host_noack) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // ucer_responder

// ==== tb/ucer_checker.sv ====
// Purpose: Port checks of the endpoint responder
// Assumes: One mclk domain, rst active high
// Notes:   Bound into every responder instance
`timescale 1ns/100ps
module ucer_checker (
  input wire       mclk,
  input wire       rst,
  input wire       tok_valid,
  input wire [1:0] tok_pid,
  input wire       tok_ready,
  input wire       rx_byte_valid,
  input wire       rx_end,
  input wire       rx_good,
  input wire       hs_valid,
  input wire [1:0] hs_code,
  input wire       tx_start,
  input wire [3:0] tx_len,
  input wire       tx_valid,
  input wire       tx_ready,
  input wire       host_ack,
  input wire       ep_irq
);
  reg  [4:0] n_rx;
  wire       take = tok_valid && tok_ready;
  // Saturates so a runaway packet never wraps under the limit
  always @(posedge mclk or posedge rst)
    if (rst)
      n_rx <= 5'h00;
    else if (take)
      n_rx <= 5'h00;
    else if (rx_byte_valid && n_rx != 5'h1f)
      n_rx <= n_rx + 5'h01;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_LONG_IGNORED: assert property (rx_end && n_rx > 5'h0a |=> !hs_valid && !ep_irq)
    else $error("handshake after long packet");
  AST_BAD_IGNORED: assert property (rx_end && !rx_good |=> !hs_valid && !ep_irq)
    else $error("handshake after bad packet");
  AST_IN_NO_ACK: assert property (take && tok_pid == 2'h1 |=> !(hs_valid && hs_code == 2'h0))
    else $error("IN token got ACK");
  AST_NAK_QUIET: assert property (hs_valid && hs_code == 2'h1 |-> !ep_irq)
    else $error("NAK raised irq");
  AST_ACK_IRQ: assert property (hs_valid && hs_code == 2'h0 |-> ep_irq)
    else $error("ACK without irq");
  AST_HOST_ACK: assert property (host_ack |=> ep_irq)
    else $error("no irq after host ack");
  AST_TX_ZERO: assert property (tx_start && tx_len == 4'h0 |=> !tx_valid [*2])
    else $error("data in zero-length packet");
  AST_TOK_BUSY: assert property (take |=> !tok_ready)
    else $error("token taken while busy");
  cover property (hs_valid && hs_code == 2'h2);
  cover property (tx_valid && !tx_ready);
  cover property (host_ack);
endmodule // ucer_checker

bind ucer_responder ucer_checker i_ucer_checker (
  .mclk, .rst, .tok_valid, .tok_pid, .tok_ready, .rx_byte_valid, .rx_end, .rx_good,
  .hs_valid, .hs_code, .tx_start, .tx_len, .tx_valid, .tx_ready, .host_ack, .ep_irq
);

// ==== tb/ucer_host.sv ====
// Purpose: USB host model at the decoded token side
// Assumes: Tokens and packets arrive as byte events
// Notes:   Released data lines show inverted values
`timescale 1ns/100ps
module ucer_host (
  input  wire       mclk,
  input  wire       tok_ready,
  input  wire       hs_valid,
  input  wire [1:0] hs_code,
  input  wire       tx_start,
  input  wire [3:0] tx_len,
  input  wire       tx_valid,
  input  wire [7:0] tx_data,
  input  wire       ep_irq,
  output reg        tok_valid = 1'b0,
  output reg  [1:0] tok_pid = 2'h0,
  output reg        rx_byte_valid = 1'b0,
  output reg  [7:0] rx_byte = 8'h00,
  output reg        rx_end = 1'b0,
  output reg        rx_good = 1'b0,
  output reg        rx_toggle = 1'b0,
  output reg        tx_ready = 1'b1,
  output reg        host_ack = 1'b0,
  output reg        host_noack = 1'b0
);
  reg       slow = 1'b0, hsv, irq, txs;
  reg [1:0] hsc;
  reg [3:0] tl, nt;
  reg [7:0] rxd [0:7];
  // Slow host takes a byte only every other cycle
  always @(posedge mclk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (hs_valid)
      {hsv, hsc} <= {1'b1, hs_code};
    if (ep_irq)
      irq <= 1'b1;
    if (tx_start)
      {txs, tl} <= {1'b1, tx_len};
    if (tx_valid && tx_ready) begin
      rxd[nt[2:0]] <= tx_data;
      nt <= nt + 4'h1;
    end
  end
  task xfer(input [1:0] pid, input [4:0] n, input g, input t, input a);
    integer i;
    begin
      {hsv, irq, txs, hsc, nt} <= 9'h0;
      tok_valid <= 1'b1;
      tok_pid <= pid;
      // Token held until taken; the bench watchdog catches a hang
      do begin
        @(posedge mclk);
      end while (tok_ready !== 1'b1);
      tok_valid <= 1'b0;
      tok_pid <= ~pid;
      if (pid != 2'h1) begin
        for (i = 0; i < n; i = i + 1) begin
          @(posedge mclk);
          rx_byte_valid <= 1'b1;
          rx_byte <= 8'ha0 + i[7:0];
        end
        @(posedge mclk);
        {rx_byte_valid, rx_end, rx_good, rx_toggle} <= {1'b0, 1'b1, g, t};
        rx_byte <= ~rx_byte;
        @(posedge mclk);
        {rx_end, rx_good, rx_toggle} <= {1'b0, ~g, ~t};
      end else begin
        repeat (3) @(posedge mclk);
        if (txs) begin
          repeat (16) @(posedge mclk);
          {host_ack, host_noack} <= {a, ~a};
          @(posedge mclk);
          {host_ack, host_noack} <= 2'b00;
        end
      end
      repeat (4) @(posedge mclk);
    end
  endtask
endmodule // ucer_host

// ==== tb/usb_control_endpoint_responder_tb.sv ====
// Purpose: Self-checking bench of the endpoint responder
// Assumes: APB master and host model share mclk
// Notes:   Each mode write clears the flag bits
`timescale 1ns/100ps
`include "ucer_map.vh"
module usb_control_endpoint_responder_tb;
  reg         mclk = 1'b0, rst = 1'b1, ce = 1'b1, err;
  reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00, k;
  reg  [31:0] pwdata = 32'h0, rd;
  wire [31:0] prdata;
  wire        pready, pslverr, tok_valid, tok_ready, rx_byte_valid, rx_end, rx_good;
  wire        rx_toggle, hs_valid, tx_start, tx_valid, tx_ready, host_ack, host_noack, ep_irq;
  wire [1:0]  tok_pid, hs_code;
  wire [3:0]  tx_len;
  wire [7:0]  rx_byte, tx_data;
  integer     n_fail = 0, total_checks = 0;
  localparam [1:0] SU = `UCER_TOK_SETUP, TI = `UCER_TOK_IN, TO = `UCER_TOK_OUT;
  localparam [7:0] AM = `UCER_OFF_MODE, AC = `UCER_OFF_COUNT, AB = `UCER_OFF_BUF;
  localparam [2:0] HA = 3'h4, HN = 3'h5, HS = 3'h6;
  ucer_responder #(.AW(8)) i_ucer_responder (
    .mclk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .tok_valid, .tok_pid, .tok_ready, .rx_byte_valid, .rx_byte, .rx_end, .rx_good,
    .rx_toggle, .hs_valid, .hs_code, .tx_start, .tx_len, .tx_valid, .tx_data, .tx_ready,
    .host_ack, .host_noack, .ep_irq
  );
  ucer_host i_ucer_host (
    .mclk, .tok_ready, .hs_valid, .hs_code, .tx_start, .tx_len, .tx_valid, .tx_data,
    .ep_irq, .tok_valid, .tok_pid, .rx_byte_valid, .rx_byte, .rx_end, .rx_good,
    .rx_toggle, .tx_ready, .host_ack, .host_noack
  );
  initial begin
    forever #25 mclk = ~mclk;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Waits for pready however long it takes; only the watchdog ends a hang
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge mclk);
      penable <= 1'b1;
      do begin
        @(posedge mclk);
      end while (pready !== 1'b1);
      {rd, err} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
      @(posedge mclk);
    end
  endtask
  // Only supported mode codes are ever written
  task step(input [3:0] m, input [1:0] p, input [4:0] n, input g, t, a,
            input [2:0] eh, input ei, input [7:0] em);
    begin
      apb(1'b1, AM, {28'h0, m});
      i_ucer_host.xfer(p, n, g, t, a);
      chk({i_ucer_host.hsv, i_ucer_host.hsc}, eh);
      chk(i_ucer_host.irq, ei);
      apb(1'b0, AM, 32'h0);
      chk(rd, em);
    end
  endtask
  task t_regs;
    begin
      apb(1'b0, AM, 32'h0);
      chk(rd, `UCER_RST_MODE);
      apb(1'b0, 8'h10, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      $display("regs done");
    end
  endtask
  task t_ignore;
    begin
      step(4'h0, SU, 5'd8, 1, 0, 0, 0, 0, 8'h00);
      step(4'h0, TI, 5'd0, 0, 0, 1, 0, 0, 8'h00);
      step(4'h3, SU, 5'd11, 1, 0, 0, 0, 0, 8'h03);
      step(4'h3, SU, 5'd8, 0, 0, 0, 0, 0, 8'h03);
      step(4'h1, SU, 5'd11, 1, 0, 0, 0, 0, 8'h01);
      $display("ignore done");
    end
  endtask
  task t_setup;
    begin
      step(4'h3, SU, 5'd8, 1, 0, 0, HA, 1, 8'h91);
      apb(1'b0, AC, 32'h0);
      chk(rd, 8'h48);
      apb(1'b0, AB + 8'h1c, 32'h0);
      chk(rd, 8'ha7);
      $display("setup done");
    end
  endtask
  task t_nak_stall;
    begin
      step(4'h1, TI, 5'd0, 0, 0, 0, HN, 0, 8'h01);
      step(4'h1, TO, 5'd4, 1, 0, 0, HN, 0, 8'h01);
      step(4'h1, TO, 5'd11, 1, 0, 0, 0, 0, 8'h01);
      step(4'h3, TI, 5'd0, 0, 0, 0, HS, 0, 8'h03);
      step(4'h3, TO, 5'd3, 1, 0, 0, HS, 0, 8'h03);
      step(4'h3, TO, 5'd3, 0, 0, 0, 0, 0, 8'h03);
      $display("nak stall done");
    end
  endtask
  task t_data_in;
    begin
      for (k = 0; k < 3; k = k + 1)
        apb(1'b1, AB + (k << 2), {24'h0, 8'h50 + k});
      apb(1'b1, AC, 32'h3);
      i_ucer_host.slow <= 1'b1;
      step(4'hf, TI, 5'd0, 0, 0, 0, 0, 0, 8'h0f);
      chk({i_ucer_host.tl, i_ucer_host.nt}, 8'h33);
      for (k = 0; k < 3; k = k + 1)
        chk(i_ucer_host.rxd[k], 8'h50 + k);
      step(4'hf, TI, 5'd0, 0, 0, 1, 0, 1, 8'h51);
      i_ucer_host.slow <= 1'b0;
      $display("data in done");
    end
  endtask
  task t_status;
    begin
      step(4'hf, TO, 5'd3, 1, 1, 0, HS, 1, 8'h03);
      step(4'hf, TO, 5'd2, 1, 0, 0, HS, 1, 8'h03);
      step(4'hf, TO, 5'd2, 1, 1, 0, HA, 1, 8'h32);
      apb(1'b0, AC, 32'h0);
      chk(rd, 8'hc2);
      step(4'h2, TO, 5'd2, 1, 1, 0, HA, 1, 8'h32);
      step(4'h2, TI, 5'd0, 0, 0, 0, HS, 1, 8'h03);
      step(4'h2, TO, 5'd0, 1, 1, 0, HS, 1, 8'h03);
      step(4'h2, TO, 5'd2, 1, 0, 0, HS, 1, 8'h03);
      $display("status done");
    end
  endtask
  task t_zero;
    begin
      step(4'hb, TI, 5'd0, 0, 0, 0, 0, 0, 8'h0b);
      chk({i_ucer_host.txs, i_ucer_host.tl}, 5'h10);
      step(4'hb, TI, 5'd0, 0, 0, 1, 0, 1, 8'h53);
      // Remaining control codes: good OUT in 1011, status-in mode 0110
      step(4'hb, TO, 5'd5, 1, 1, 0, HA, 1, 8'h31);
      apb(1'b0, AC, 32'h0);
      chk(rd, 8'hc5);
      step(4'h6, TI, 5'd0, 0, 0, 1, 0, 1, 8'h53);
      step(4'h6, TO, 5'd2, 1, 1, 0, HS, 1, 8'h03);
      step(4'h6, TO, 5'd2, 0, 1, 0, 0, 0, 8'h06);
      $display("zero done");
    end
  endtask
  task finish_test;
    begin
      $display("checks=%0d mismatches=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_regs;
    t_ignore;
    t_setup;
    t_nak_stall;
    t_data_in;
    t_status;
    t_zero;
    finish_test;
  end
  // About thirty times the expected run length
  initial begin
    #1000000;
    n_fail = n_fail + 1;
    finish_test;
  end
endmodule // usb_control_endpoint_responder_tb
